// ==== verilog/dsc_cfg.svh ====
// Address map, reset values and timing constants of the data set changeover selector.
`ifndef DSC_CFG_SVH
`define DSC_CFG_SVH

// Register byte addresses and parameter bank codes on the AXI4-Lite slave.
`define DSC_ADDR_SOURCE    8'h00
`define DSC_ADDR_THRESHOLD 8'h04
`define DSC_ADDR_STATUS    8'h08
`define DSC_SET_ONE_BANK   2'h1
`define DSC_SET_TWO_BANK   2'h2

// Reset values and threshold limits of the software settings.
`define DSC_SOURCE_RESET   3'h0
`define DSC_THRESH_RESET   16'h0258
`define DSC_THRESH_MAX     16'h7ffc
`define DSC_THRESH_MIN     16'h8004

// AXI response codes.
`define DSC_RESP_OKAY      2'h0
`define DSC_RESP_SLVERR    2'h2

// Control cycle period and clock period, both in ns.
`define DSC_CTRL_CYCLE_NS  1000
`define DSC_CLK_PERIOD_NS  20

`endif

// ==== verilog/dsc_pkg.sv ====
// Types shared by the data set changeover selector modules.
package dsc_pkg;

    // Changeover source codes as seen by software.
    typedef enum logic [2:0] {
        SRC_OFF      = 3'h0,
        SRC_SPEED    = 3'h1,
        SRC_INPUT    = 3'h2,
        SRC_ROTATION = 3'h3,
        SRC_SERIAL   = 3'h4,
        SRC_CAN      = 3'h5,
        SRC_OPTION   = 3'h6,
        SRC_ABS      = 3'h7
    } select_src_e;

    typedef logic [15:0] param_word_t;

endpackage

// ==== verilog/level_sync.sv ====
// Two flip-flop synchroniser for a level arriving from a pin.
module level_sync (
    input  wire logic ref_clk,
    input  wire logic nrst,
    input  wire logic async_in,
    output logic      sync_out
);

    logic first_reg;

    // The first stage feeds only the second, so metastability stays contained.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            first_reg <= 1'b0;
            sync_out  <= 1'b0;
        end else begin
            first_reg <= async_in;
            sync_out  <= first_reg;
        end
    end

endmodule

// ==== verilog/cycle_divider.sv ====
// Divider that produces the one-cycle control cycle enable.
module cycle_divider #(
    parameter int DIV = 50
) (
    input  wire logic ref_clk,
    input  wire logic nrst,
    output logic      cycle_en
);

    localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

    logic [CW-1:0] count_reg;
    wire           wrap = (count_reg == CW'(DIV - 1));

    // The pulse comes at the wrap so the first control cycle is DIV clocks after reset.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            count_reg <= '0;
            cycle_en  <= 1'b0;
        end else begin
            count_reg <= wrap ? '0 : count_reg + 1'b1;
            cycle_en  <= wrap;
        end
    end

endmodule

// ==== verilog/data_set_changeover_selector.sv ====
// Data set changeover selector with its AXI4-Lite register slave.
//
// Overview of operation
// RULE1: A source setting picks how the set is chosen; off keeps set one.
// RULE2: Source 1 gives set two while speed setpoint exceeds threshold, else set one.
// RULE3: Source 2 gives set two while the assigned digital input is high.
// RULE4: Source 3 gives set two on counter-clockwise rotation, set one clockwise.
// RULE5: Sources 4, 5, 6 follow serial, CAN or option slot control bit.
// RULE6: Source 7 gives set two when speed magnitude exceeds the threshold.
// RULE7: Threshold is signed rpm, limited to plus or minus 32764, reset 600.
// RULE8: The active set is readable and reads zero after reset.
// RULE9: Active set reads 0 for set one and 1 for set two.
// RULE10: Sets may change while running, control never stops.
// RULE11: All curve parameters of the selected set switch together.
// RULE12: Selection is evaluated each control cycle and applies the next cycle.
//
// Decided for this implementation: the register offsets and the AXI4-Lite interface to the registers.
`include "dsc_cfg.svh"

module data_set_changeover_selector
    import dsc_pkg::*;
#(
    parameter int PARAM_COUNT = 10,
    parameter int CYCLE_DIV   = `DSC_CTRL_CYCLE_NS / `DSC_CLK_PERIOD_NS
) (
    input  wire logic                          ref_clk,
    input  wire logic                          nrst,
    input  wire logic [7:0]                    s_axi_awaddr,
    input  wire logic [2:0]                    s_axi_awprot,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [31:0]                   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    input  wire logic [7:0]                    s_axi_araddr,
    input  wire logic [2:0]                    s_axi_arprot,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    output logic [31:0]                        s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    input  wire logic signed [15:0]            speed_setpoint,
    input  wire logic                          rotation_direction_source,
    input  wire logic                          assigned_digital_input,
    input  wire logic                          serial_link_source,
    input  wire logic                          can_link_source,
    input  wire logic                          option_slot_source,
    output logic                               active_set_indicator,
    output logic [PARAM_COUNT-1:0][15:0]       set_params,
    output logic                               ctrl_cycle
);

    ////////////////////////////////////////////////////////////////////////////
    // Helper functions.

    // Byte-lane merge of a 16-bit register with a write beat.
    function automatic param_word_t merge_lanes(input param_word_t old_v,
                                                input logic [31:0]  data,
                                                input logic [3:0]   strb);
        param_word_t r;
        r = old_v;
        if (strb[0]) begin
            r[7:0] = data[7:0];
        end
        if (strb[1]) begin
            r[15:8] = data[15:8];
        end
        return r;
    endfunction

    // Bank and item decode of a parameter address; item must be inside the set.
    function automatic logic param_hit(input logic [7:0] addr, input logic [1:0] bank);
        return (addr[7:6] == bank) && (32'(addr[5:2]) < PARAM_COUNT) && (addr[1:0] == 2'h0);
    endfunction

    // Signed comparison against the threshold, optionally on the magnitude.
    function automatic logic exceeds(input logic signed [15:0] speed,
                                     input logic signed [15:0] thr,
                                     input logic               use_abs);
        logic signed [16:0] s;
        s = {speed[15], speed};
        if (use_abs && s < 17'sd0) begin
            s = -s;
        end
        return s > $signed({thr[15], thr});
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // State.

    logic [2:0]          source_reg;
    logic signed [15:0]  threshold_reg;
    logic                active_set_reg;
    param_word_t         set_mem [0:2*PARAM_COUNT-1];
    logic                aw_hold_reg;
    logic [7:0]          awaddr_reg;
    logic                w_hold_reg;
    logic [31:0]         wdata_reg;
    logic [3:0]          wstrb_reg;
    logic                bvalid_reg;
    logic [1:0]          bresp_reg;
    logic                rvalid_reg;
    logic [31:0]         rdata_reg;
    logic [1:0]          rresp_reg;
    logic                input_sync;
    logic                cycle_en;

    // The digital input is a pin and crosses into the clock domain first.
    level_sync u_input_sync (
        .ref_clk  (ref_clk),
        .nrst     (nrst),
        .async_in (assigned_digital_input),
        .sync_out (input_sync)
    );

    // Control cycle enable; the set is only re-evaluated on this pulse.
    cycle_divider #(
        .DIV (CYCLE_DIV)
    ) u_cycle_divider (
        .ref_clk  (ref_clk),
        .nrst     (nrst),
        .cycle_en (cycle_en)
    );

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write path.

    // Address and data are taken independently and held until both are present.
    wire aw_take  = s_axi_awvalid && s_axi_awready;
    wire w_take   = s_axi_wvalid && s_axi_wready;
    wire do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;

    wire wr_source = (awaddr_reg == `DSC_ADDR_SOURCE);
    wire wr_thresh = (awaddr_reg == `DSC_ADDR_THRESHOLD);
    wire wr_status = (awaddr_reg == `DSC_ADDR_STATUS);
    wire wr_set1   = param_hit(awaddr_reg, `DSC_SET_ONE_BANK);
    wire wr_set2   = param_hit(awaddr_reg, `DSC_SET_TWO_BANK);
    wire wr_mapped = wr_source || wr_thresh || wr_status || wr_set1 || wr_set2;
    wire [4:0] wr_index = 5'(32'(awaddr_reg[5:2]) + (wr_set2 ? PARAM_COUNT : 0));

    // Threshold writes are clamped to the allowed range rather than refused.
    wire param_word_t thr_merged = merge_lanes(threshold_reg, wdata_reg, wstrb_reg);
    wire signed [15:0] thr_clamped =
        ($signed(thr_merged) > $signed(`DSC_THRESH_MAX)) ? `DSC_THRESH_MAX :
        ($signed(thr_merged) < $signed(`DSC_THRESH_MIN)) ? `DSC_THRESH_MIN : $signed(thr_merged);

    assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
    assign s_axi_wready  = !w_hold_reg && !bvalid_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;

    // Channel holding registers and the write response.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            aw_hold_reg <= 1'b0;
            awaddr_reg  <= 8'h00;
            w_hold_reg  <= 1'b0;
            wdata_reg   <= 32'h0;
            wstrb_reg   <= 4'h0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= `DSC_RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_hold_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr;
            end
            if (w_take) begin
                w_hold_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata;
                wstrb_reg  <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_hold_reg <= 1'b0;
                w_hold_reg  <= 1'b0;
                bvalid_reg  <= 1'b1;
                bresp_reg   <= wr_mapped ? `DSC_RESP_OKAY : `DSC_RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // Settings registers; the status word is read-only and ignores writes.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            source_reg    <= `DSC_SOURCE_RESET; // RULE1
            threshold_reg <= `DSC_THRESH_RESET; // RULE7
        end else if (do_write) begin
            if (wr_source && wstrb_reg[0]) begin
                source_reg <= wdata_reg[2:0];
            end
            if (wr_thresh) begin
                threshold_reg <= thr_clamped; // RULE7
            end
        end
    end

    // Both curve sets live here so software can load set two while set one drives.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < 2 * PARAM_COUNT; i++) begin
                set_mem[i] <= 16'h0000;
            end
        end else if (do_write && (wr_set1 || wr_set2)) begin
            set_mem[wr_index] <= merge_lanes(set_mem[wr_index], wdata_reg, wstrb_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read path.

    wire ar_take   = s_axi_arvalid && s_axi_arready;
    wire rd_set1   = param_hit(s_axi_araddr, `DSC_SET_ONE_BANK);
    wire rd_set2   = param_hit(s_axi_araddr, `DSC_SET_TWO_BANK);
    wire [4:0] rd_index = 5'(32'(s_axi_araddr[5:2]) + (rd_set2 ? PARAM_COUNT : 0));
    wire rd_mapped = (s_axi_araddr == `DSC_ADDR_SOURCE) || (s_axi_araddr == `DSC_ADDR_THRESHOLD) ||
                     (s_axi_araddr == `DSC_ADDR_STATUS) || rd_set1 || rd_set2;
    wire [31:0] rd_value =
        (s_axi_araddr == `DSC_ADDR_SOURCE)    ? {29'h0, source_reg} :
        (s_axi_araddr == `DSC_ADDR_THRESHOLD) ? {{16{threshold_reg[15]}}, threshold_reg} :
        (s_axi_araddr == `DSC_ADDR_STATUS)    ? {31'h0, active_set_reg} : // RULE8
        (rd_set1 || rd_set2)                  ? {16'h0, set_mem[rd_index]} : 32'h0;

    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;

    // Read data is captured at the address handshake and held until taken.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0;
            rresp_reg  <= `DSC_RESP_OKAY;
        end else if (ar_take) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= rd_value;
            rresp_reg  <= rd_mapped ? `DSC_RESP_OKAY : `DSC_RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Set selection.

    logic want_set_two;

    // Decision for the current source; off and unknown codes both mean set one.
    always_comb begin
        case (select_src_e'(source_reg))
            SRC_OFF:      want_set_two = 1'b0; // RULE1
            SRC_SPEED:    want_set_two = exceeds(speed_setpoint, threshold_reg, 1'b0); // RULE2
            SRC_INPUT:    want_set_two = input_sync; // RULE3
            SRC_ROTATION: want_set_two = rotation_direction_source; // RULE4
            SRC_SERIAL:   want_set_two = serial_link_source; // RULE5
            SRC_CAN:      want_set_two = can_link_source; // RULE5
            SRC_OPTION:   want_set_two = option_slot_source; // RULE5
            SRC_ABS:      want_set_two = exceeds(speed_setpoint, threshold_reg, 1'b1); // RULE6
            default:      want_set_two = 1'b0;
        endcase
    end

    // The set changes only on a control cycle edge, never in mid cycle, and
    // the output stage keeps running throughout so control is never interrupted.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            active_set_reg <= 1'b0; // RULE8
        end else if (cycle_en) begin
            active_set_reg <= want_set_two; // RULE12 RULE10
        end
    end

    assign active_set_indicator = active_set_reg; // RULE9
    assign ctrl_cycle           = cycle_en;

    // All items are taken from one bank in the same clock so no mixed set is seen.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            set_params <= '0;
        end else begin
            for (int i = 0; i < PARAM_COUNT; i++) begin
                set_params[i] <= set_mem[active_set_reg ? i + PARAM_COUNT : i]; // RULE11
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions and coverage.

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    wire param_word_t first_item = set_mem[active_set_reg ? PARAM_COUNT : 0];
    wire param_word_t last_item  = set_mem[active_set_reg ? 2 * PARAM_COUNT - 1 : PARAM_COUNT - 1];
    wire              bus_bit    = (source_reg == SRC_SERIAL) ? serial_link_source :
                                   (source_reg == SRC_CAN)    ? can_link_source : option_slot_source;

    property p_off_keeps_one;
        (source_reg == SRC_OFF) && cycle_en |=> !active_set_reg;
    endproperty
    a_off_keeps_one: assert property (p_off_keeps_one) else $error("Off source did not keep set one."); // RULE1

    property p_speed_threshold;
        (source_reg == SRC_SPEED) && cycle_en |=>
            active_set_reg == ($past(speed_setpoint) > $past(threshold_reg));
    endproperty
    a_speed_threshold: assert property (p_speed_threshold) else $error("Speed threshold choice wrong."); // RULE2

    property p_digital_input;
        (source_reg == SRC_INPUT) && cycle_en |=> active_set_reg == $past(input_sync);
    endproperty
    a_digital_input: assert property (p_digital_input) else $error("Digital input choice wrong."); // RULE3

    property p_rotation;
        (source_reg == SRC_ROTATION) && cycle_en |=> active_set_reg == $past(rotation_direction_source);
    endproperty
    a_rotation: assert property (p_rotation) else $error("Rotation choice wrong."); // RULE4

    property p_bus_bit;
        (source_reg inside {SRC_SERIAL, SRC_CAN, SRC_OPTION}) && cycle_en |=> active_set_reg == $past(bus_bit);
    endproperty
    a_bus_bit: assert property (p_bus_bit) else $error("Bus control bit choice wrong."); // RULE5

    property p_abs_speed;
        (source_reg == SRC_ABS) && cycle_en && (speed_setpoint == 16'sh8000) && (threshold_reg >= 16'sh0000)
            |=> active_set_reg;
    endproperty
    a_abs_speed: assert property (p_abs_speed) else $error("Magnitude comparison lost sign."); // RULE6

    property p_threshold_range;
        (threshold_reg <= $signed(`DSC_THRESH_MAX)) && (threshold_reg >= $signed(`DSC_THRESH_MIN));
    endproperty
    a_threshold_range: assert property (p_threshold_range) else $error("Threshold out of range."); // RULE7

    property p_status_read;
        ar_take && (s_axi_araddr == `DSC_ADDR_STATUS) |=> s_axi_rvalid && (s_axi_rdata == {31'h0, $past(active_set_reg)});
    endproperty
    a_status_read: assert property (p_status_read) else $error("Status read mismatch."); // RULE8 RULE9

    property p_hold_between_cycles;
        !cycle_en |=> $stable(active_set_reg);
    endproperty
    a_hold_between_cycles: assert property (p_hold_between_cycles) else $error("Set changed off cycle."); // RULE12

    property p_items_together;
        1'b1 |=> (set_params[0] == $past(first_item)) && (set_params[PARAM_COUNT-1] == $past(last_item));
    endproperty
    a_items_together: assert property (p_items_together) else $error("Curve items not from one set."); // RULE11 RULE10

    property p_write_answer;
        do_write |=> s_axi_bvalid;
    endproperty
    a_write_answer: assert property (p_write_answer) else $error("Write response missing.");

    c_switch_to_two: cover property (cycle_en && want_set_two && !active_set_reg ##1 active_set_reg);
    c_switch_to_one: cover property (cycle_en && !want_set_two && active_set_reg ##1 !active_set_reg);
    c_abs_mode_two:  cover property ((source_reg == SRC_ABS) && speed_setpoint < 16'sh0000 ##1 active_set_reg);
    c_unmapped_read: cover property (ar_take && !rd_mapped);

endmodule

// ==== dv/drive_side_model.sv ====
// Behavioural drive core, digital input pin and field bus masters that feed the selector.
module drive_side_model (
    input  wire logic               ref_clk,
    input  wire logic [15:0]        spd_req,
    input  wire logic [4:0]         bit_req,
    output logic signed [15:0]      speed_setpoint,
    output logic                    rotation_direction_source,
    output logic                    assigned_digital_input,
    output logic                    serial_link_source,
    output logic                    can_link_source,
    output logic                    option_slot_source
);
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////////////
    // Every source updates just after a clock edge and then holds its level.
    // The bus masters own a control bit each; high asks for set two.
    always @(posedge ref_clk) begin
        speed_setpoint            <= spd_req;
        rotation_direction_source <= bit_req[0];
        assigned_digital_input    <= bit_req[1];
        serial_link_source        <= bit_req[2];
        can_link_source           <= bit_req[3];
        option_slot_source        <= bit_req[4];
    end
endmodule

// ==== dv/tb.sv ====
// Self-checking bench for the data set changeover selector.
`include "dsc_cfg.svh"

module tb;
    import dsc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int PC = 10;
    typedef struct {string name; logic [33:0] val;} note_s;

    logic ref_clk, nrst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, active_set_indicator, ctrl_cycle;
    logic [7:0]              s_axi_awaddr, s_axi_araddr;
    logic [31:0]             s_axi_wdata, s_axi_rdata, seed;
    logic [3:0]              s_axi_wstrb;
    logic [1:0]              s_axi_bresp, s_axi_rresp;
    logic [15:0]             spd_req;
    logic [4:0]              bit_req;
    logic [PC-1:0][15:0]     set_params;
    logic signed [15:0]      speed_setpoint;
    logic                    rotation_direction_source, assigned_digital_input;
    logic                    serial_link_source, can_link_source, option_slot_source;
    int                      fail_count, checked;
    note_s                   notes[$];
    note_s                   nt;

    data_set_changeover_selector #(.PARAM_COUNT(PC), .CYCLE_DIV(4)) i_data_set_changeover_selector (
        .ref_clk, .nrst, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .speed_setpoint, .rotation_direction_source, .assigned_digital_input,
        .serial_link_source, .can_link_source, .option_slot_source, .active_set_indicator, .set_params,
        .ctrl_cycle);

    drive_side_model i_drive_side_model (.ref_clk, .spd_req, .bit_req, .speed_setpoint,
        .rotation_direction_source, .assigned_digital_input, .serial_link_source, .can_link_source,
        .option_slot_source);

    ////////////////////////////////////////////////////////////////////////////
    // Clock at 50 MHz.
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    // Comparison helper; every comparison is counted.
    task automatic check(string name, logic [33:0] seen, logic [33:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Threshold writes beyond the legal span settle on the nearest limit.
    function automatic logic signed [15:0] clampt(logic signed [15:0] t);
        if (t > 16'sh7ffc) return 16'sh7ffc;
        if (t < -16'sh7ffc) return -16'sh7ffc;
        return t;
    endfunction

    // Set wanted for a source code; b is {option, can, serial, input, rotation}.
    function automatic logic want_two(logic [2:0] s, logic signed [15:0] spd, logic signed [15:0] thr,
                                      logic [4:0] b);
        int mag;
        mag = (spd < 0) ? -int'(spd) : int'(spd);
        case (s)
            3'h1:    return spd > thr;
            3'h2:    return b[1];
            3'h3:    return b[0];
            3'h4:    return b[2];
            3'h5:    return b[3];
            3'h6:    return b[4];
            3'h7:    return mag > int'(thr);
            default: return 1'b0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Bus master tasks; a handshake is judged at the falling edge before the taking edge to avoid races.
    task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] rsp);
        logic da, dw, ta, tw, b;
        notes.push_back('{$sformatf("write %h", a), {rsp, 32'h0}});
        da = 1'b0;
        dw = 1'b0;
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(da && dw)) begin
            @(negedge ref_clk);
            ta = !da && s_axi_awready;
            tw = !dw && s_axi_wready;
            @(posedge ref_clk);
            if (ta) begin s_axi_awvalid <= 1'b0; da = 1'b1; end
            if (tw) begin s_axi_wvalid <= 1'b0; dw = 1'b1; end
        end
        do begin @(negedge ref_clk); b = s_axi_bvalid; @(posedge ref_clk); end while (!b);
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(logic [7:0] a, logic [33:0] exp);
        logic t;
        notes.push_back('{$sformatf("read %h", a), exp});
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin @(negedge ref_clk); t = s_axi_arready; @(posedge ref_clk); end while (!t);
        s_axi_arvalid <= 1'b0;
        do begin @(negedge ref_clk); t = s_axi_rvalid; @(posedge ref_clk); end while (!t);
        s_axi_rready <= 1'b0;
    endtask

    // Waits for n control cycle pulses.
    task automatic wait_pulse(int n);
        repeat (n) begin
            do @(negedge ref_clk); while (ctrl_cycle !== 1'b1);
            @(posedge ref_clk);
        end
    endtask

    // Response watcher: the oldest note is matched against each completed answer.
    always @(negedge ref_clk) begin
        if (nrst && ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready))) begin
            nt = notes.pop_front();
            check(nt.name, s_axi_bvalid ? {s_axi_bresp, 32'h0} : {s_axi_rresp, s_axi_rdata}, nt.val);
        end
    end

    // A hung handshake ends the run as a mismatch.
    initial begin
        #100000;
        fail_count++;
        $display("watchdog expired");
        conclude();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence: reset values, map corners, then every source code against random inputs.
    initial begin
        logic signed [15:0] spd, thr, thc;
        logic [31:0] r;
        logic [4:0] fl;
        logic e;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hf;
        spd_req = 16'h0;
        bit_req = 5'h0;
        seed = 32'h640b4990;
        fail_count = 0;
        checked = 0;
        nrst = 1'b0;
        repeat (3) @(posedge ref_clk);
        nrst <= 1'b1;
        rd(`DSC_ADDR_SOURCE, 34'h0);
        rd(`DSC_ADDR_THRESHOLD, {`DSC_RESP_OKAY, 32'h258});
        rd(`DSC_ADDR_STATUS, 34'h0);
        rd(8'h30, {`DSC_RESP_SLVERR, 32'h0});
        wr(8'h30, 32'h1, `DSC_RESP_SLVERR);
        wr(`DSC_ADDR_STATUS, 32'h1, `DSC_RESP_OKAY);
        rd(`DSC_ADDR_STATUS, 34'h0);
        wr(8'h40, 32'h0a11, `DSC_RESP_OKAY);
        wr(8'(8'h40 + 4 * (PC - 1)), 32'h0a99, `DSC_RESP_OKAY);
        wr(8'h80, 32'h0b22, `DSC_RESP_OKAY);
        wr(8'(8'h80 + 4 * (PC - 1)), 32'h0b88, `DSC_RESP_OKAY);
        rd(8'h80, {`DSC_RESP_OKAY, 32'h0b22});
        $display("test reset done");
        for (int i = 0; i < 16; i++) begin
            r = rnd();
            spd = r[15:0];
            thr = r[31:16];
            if (i == 9) thr = spd; // Equal values must not switch: the compare is strict.
            if (i == 15) begin spd = 16'sh8000; thr = 16'sh7ffc; end
            if (i == 3) thr = 16'sh7fff; // Clamp corners.
            if (i == 4) thr = 16'sh8000;
            fl = 5'(1 << ((i % 8 < 4) ? ((i % 8 == 3) ? 0 : 1) : i % 8 - 2)) ^ {5{~i[3]}};
            wr(`DSC_ADDR_SOURCE, {29'h0, 3'(i)}, `DSC_RESP_OKAY);
            wr(`DSC_ADDR_THRESHOLD, {16'h0, thr}, `DSC_RESP_OKAY);
            thc = clampt(thr);
            rd(`DSC_ADDR_THRESHOLD, {`DSC_RESP_OKAY, {16{thc[15]}}, thc});
            spd_req <= spd;
            bit_req <= fl;
            e = want_two(3'(i), spd, thc, fl);
            wait_pulse(3);
            repeat (2) @(posedge ref_clk);
            @(negedge ref_clk);
            check("indicator", {33'h0, active_set_indicator}, {33'h0, e});
            check("first item", {18'h0, set_params[0]}, e ? 34'h0b22 : 34'h0a11);
            check("last item", {18'h0, set_params[PC-1]}, e ? 34'h0b88 : 34'h0a99);
            rd(`DSC_ADDR_STATUS, {`DSC_RESP_OKAY, 31'h0, e});
            $display("test source %0d done", i);
        end
        conclude();
    end
endmodule
